/* File: logic/rips_pkg.sv */
// Constants, types and helpers for the remappable input selector part.
// Assumes one AHB-Lite slave port with 32-bit data and a single system clock.
package rips_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  // Number of select registers held by this part.
  localparam int RIPS_NREG = 10;
  // Number of remappable pins a select code can reach.
  localparam int RIPS_NPIN = 256;
  // Width of one select field.
  localparam int RIPS_FLD_W = 8;

  // ****************************************************************
  // Register word indices; the byte address is four times the index
  // ****************************************************************
  localparam logic [3:0] RIPS_IDX_UART3 = 4'h0;
  localparam logic [3:0] RIPS_IDX_SPI3 = 4'h1;
  localparam logic [3:0] RIPS_IDX_SS3 = 4'h2;
  localparam logic [3:0] RIPS_IDX_TMR9 = 4'h3;
  localparam logic [3:0] RIPS_IDX_CAP9 = 4'h4;
  localparam logic [3:0] RIPS_IDX_PWM17 = 4'h5;
  localparam logic [3:0] RIPS_IDX_PWM18 = 4'h6;
  localparam logic [3:0] RIPS_IDX_PWM1312 = 4'h7;
  localparam logic [3:0] RIPS_IDX_PWM1514 = 4'h8;
  localparam logic [3:0] RIPS_IDX_SENT1 = 4'h9;

  // ****************************************************************
  // Field positions, write masks and reset value
  // ****************************************************************
  localparam int RIPS_HI_LSB = 8;
  localparam int RIPS_LO_LSB = 0;
  localparam logic [15:0] RIPS_MASK_BOTH = 16'hFFFF;
  localparam logic [15:0] RIPS_MASK_LO = 16'h00FF;
  localparam logic [15:0] RIPS_MASK_HI = 16'hFF00;
  localparam logic [15:0] RIPS_SEL_RST = 16'h0000;

  // ****************************************************************
  // Bus encodings
  // ****************************************************************
  localparam logic RIPS_HRESP_OKAY = 1'b0;
  localparam logic [15:0] RIPS_RD_PAD = 16'h0000;

  // Peripheral inputs driven by this part, one bit each.
  typedef struct packed {
    logic uart3_data_set_ready_in;
    logic uart3_receive_in;
    logic spi3_clock_in;
    logic spi3_data_in;
    logic spi3_slave_sel_in;
    logic timer9_ext_clock_in;
    logic capture9_in;
    logic compare_fault_c_in;
    logic pwm_ctrl_in_12;
    logic pwm_ctrl_in_13;
    logic pwm_ctrl_in_14;
    logic pwm_ctrl_in_15;
    logic pwm_ctrl_in_16;
    logic pwm_ctrl_in_17;
    logic pwm_ctrl_in_18;
    logic sent_rx1_in;
  } rips_periph_t;

  // Whole state of the selector.
  typedef struct packed {
    logic [RIPS_NREG-1:0][15:0] regs;
    logic [RIPS_NPIN-1:0] sync1;
    logic [RIPS_NPIN-1:0] sync2;
    rips_periph_t per;
    logic dph_wr;
    logic [3:0] dph_idx;
    logic [31:0] rdata;
  } rips_state_t;

  // Bits of each register that exist; the rest ignore writes and read zero.
  function automatic logic [15:0] rips_wmask(input logic [3:0] idx);
    logic [15:0] m;
    m = RIPS_MASK_BOTH;
    case (idx)
      RIPS_IDX_SS3, RIPS_IDX_CAP9, RIPS_IDX_PWM18: m = RIPS_MASK_LO;
      RIPS_IDX_TMR9: m = RIPS_MASK_HI;
      default: m = RIPS_MASK_BOTH;
    endcase
    return m;
  endfunction

endpackage

/* File: logic/rips_top.sv */
// Remappable input selector part: select registers on AHB-Lite and the pin muxes they steer.
// Assumes pins arrive asynchronously and the peripherals sample on clk_sys.
//
// What this block does
// - Upper uart3 byte picks data-set-ready pin.
// - Lower uart3 byte picks receive pin.
// - Upper spi3 byte picks serial clock pin.
// - Lower spi3 byte picks serial data pin.
// - Lower slave-select byte picks pin; upper unused.
// - Upper timer9 byte picks clock pin; lower unused.
// - Lower capture9 byte picks pin; upper unused.
// - Upper pwm17/fault byte picks pwm input 17.
// - Lower pwm17/fault byte picks fault C pin.
// - Upper pwm13/12 byte picks pwm input 13.
// - Lower pwm13/12 byte picks pwm input 12.
// - Upper pwm15/14 byte picks pwm input 15.
// - Lower pwm15/14 byte picks pwm input 14.
// - Upper sent1/pwm16 byte picks SENT1 input.
// - Lower sent1/pwm16 byte picks pwm input 16.
// - Unused bytes ignore writes, read zero.
// - Fields read/write, zero after reset.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module rips_top
  import rips_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Remappable pins, asynchronous to clk_sys.
  input wire logic [RIPS_NPIN-1:0] remappable_pin,
  // Peripheral inputs fed from the selected pins.
  output rips_periph_t periph_in
);

  // ****************************************************************
  // State
  // ****************************************************************
  // Registered state and its next value.
  rips_state_t st_r;
  rips_state_t st_nxt;

  // Address-phase decode of the current bus request.
  logic acc;
  logic hit;
  logic [3:0] ap_idx;

  // Select fields, named after the peripheral input they steer.
  logic [7:0] uart3_dsr_pin_sel;
  logic [7:0] uart3_rx_pin_sel;
  logic [7:0] spi3_clock_pin_sel;
  logic [7:0] spi3_data_pin_sel;
  logic [7:0] spi3_slave_sel_pin_sel;
  logic [7:0] timer9_clock_pin_sel;
  logic [7:0] capture9_pin_sel;
  logic [7:0] pwm_ctrl_in_17_pin_sel;
  logic [7:0] compare_fault_c_pin_sel;
  logic [7:0] pwm_ctrl_in_18_pin_sel;
  logic [7:0] pwm_ctrl_in_13_pin_sel;
  logic [7:0] pwm_ctrl_in_12_pin_sel;
  logic [7:0] pwm_ctrl_in_15_pin_sel;
  logic [7:0] pwm_ctrl_in_14_pin_sel;
  logic [7:0] sent_rx1_pin_sel;
  logic [7:0] pwm_ctrl_in_16_pin_sel;

  // ****************************************************************
  // Field extraction
  // ****************************************************************
  // Fields are plain slices of the registers; unused bytes stay zero by masking.
  assign uart3_dsr_pin_sel = st_r.regs[RIPS_IDX_UART3][RIPS_HI_LSB +: RIPS_FLD_W];
  assign uart3_rx_pin_sel = st_r.regs[RIPS_IDX_UART3][RIPS_LO_LSB +: RIPS_FLD_W];
  assign spi3_clock_pin_sel = st_r.regs[RIPS_IDX_SPI3][RIPS_HI_LSB +: RIPS_FLD_W];
  assign spi3_data_pin_sel = st_r.regs[RIPS_IDX_SPI3][RIPS_LO_LSB +: RIPS_FLD_W];
  assign spi3_slave_sel_pin_sel = st_r.regs[RIPS_IDX_SS3][RIPS_LO_LSB +: RIPS_FLD_W];
  assign timer9_clock_pin_sel = st_r.regs[RIPS_IDX_TMR9][RIPS_HI_LSB +: RIPS_FLD_W];
  assign capture9_pin_sel = st_r.regs[RIPS_IDX_CAP9][RIPS_LO_LSB +: RIPS_FLD_W];
  assign pwm_ctrl_in_17_pin_sel = st_r.regs[RIPS_IDX_PWM17][RIPS_HI_LSB +: RIPS_FLD_W];
  assign compare_fault_c_pin_sel = st_r.regs[RIPS_IDX_PWM17][RIPS_LO_LSB +: RIPS_FLD_W];
  assign pwm_ctrl_in_18_pin_sel = st_r.regs[RIPS_IDX_PWM18][RIPS_LO_LSB +: RIPS_FLD_W];
  assign pwm_ctrl_in_13_pin_sel = st_r.regs[RIPS_IDX_PWM1312][RIPS_HI_LSB +: RIPS_FLD_W];
  assign pwm_ctrl_in_12_pin_sel = st_r.regs[RIPS_IDX_PWM1312][RIPS_LO_LSB +: RIPS_FLD_W];
  assign pwm_ctrl_in_15_pin_sel = st_r.regs[RIPS_IDX_PWM1514][RIPS_HI_LSB +: RIPS_FLD_W];
  assign pwm_ctrl_in_14_pin_sel = st_r.regs[RIPS_IDX_PWM1514][RIPS_LO_LSB +: RIPS_FLD_W];
  assign sent_rx1_pin_sel = st_r.regs[RIPS_IDX_SENT1][RIPS_HI_LSB +: RIPS_FLD_W];
  assign pwm_ctrl_in_16_pin_sel = st_r.regs[RIPS_IDX_SENT1][RIPS_LO_LSB +: RIPS_FLD_W];

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // A transfer is taken when selected, ready and NONSEQ or SEQ.
  assign acc = hsel && hready && htrans[1];
  assign ap_idx = haddr[5:2];
  // Only aligned words inside the register window hit; all else reads zero.
  assign hit = (haddr[31:6] == 26'h0000000) && (haddr[1:0] == 2'h0)
               && (ap_idx < 4'(RIPS_NREG));

  // ****************************************************************
  // Next state
  // ****************************************************************
  // One process computes the whole next state: sync chain, register file,
  // bus data phase and the peripheral muxes.
  always_comb begin
    st_nxt = st_r;
    // Two-stage synchroniser; the first stage feeds nothing but the second.
    st_nxt.sync1 = remappable_pin;
    st_nxt.sync2 = st_r.sync1;
    // Data phase of a write: only existing bits take the new value.
    if (st_r.dph_wr) begin
      st_nxt.regs[st_r.dph_idx] = hwdata[15:0] & rips_wmask(st_r.dph_idx);
    end
    // Address phase: note a write for the next cycle.
    st_nxt.dph_wr = 1'b0;
    st_nxt.dph_idx = st_r.dph_idx;
    if (acc && hwrite && hit) begin
      st_nxt.dph_wr = 1'b1;
      st_nxt.dph_idx = ap_idx;
    end
    // Read data is taken from the next register value so that a read right
    // behind a write to the same register sees the new contents.
    st_nxt.rdata = 32'h00000000;
    if (acc && !hwrite && hit) begin
      st_nxt.rdata = {RIPS_RD_PAD, st_nxt.regs[ap_idx]};
    end
    // Each peripheral input takes the synchronised level of its chosen pin.
    // A registered output costs one cycle but keeps the mux glitch free.
    st_nxt.per.uart3_data_set_ready_in = st_r.sync2[uart3_dsr_pin_sel];
    st_nxt.per.uart3_receive_in = st_r.sync2[uart3_rx_pin_sel];
    st_nxt.per.spi3_clock_in = st_r.sync2[spi3_clock_pin_sel];
    st_nxt.per.spi3_data_in = st_r.sync2[spi3_data_pin_sel];
    st_nxt.per.spi3_slave_sel_in = st_r.sync2[spi3_slave_sel_pin_sel];
    st_nxt.per.timer9_ext_clock_in = st_r.sync2[timer9_clock_pin_sel];
    st_nxt.per.capture9_in = st_r.sync2[capture9_pin_sel];
    st_nxt.per.pwm_ctrl_in_17 = st_r.sync2[pwm_ctrl_in_17_pin_sel];
    st_nxt.per.compare_fault_c_in = st_r.sync2[compare_fault_c_pin_sel];
    st_nxt.per.pwm_ctrl_in_13 = st_r.sync2[pwm_ctrl_in_13_pin_sel];
    st_nxt.per.pwm_ctrl_in_12 = st_r.sync2[pwm_ctrl_in_12_pin_sel];
    st_nxt.per.pwm_ctrl_in_15 = st_r.sync2[pwm_ctrl_in_15_pin_sel];
    st_nxt.per.pwm_ctrl_in_14 = st_r.sync2[pwm_ctrl_in_14_pin_sel];
    st_nxt.per.sent_rx1_in = st_r.sync2[sent_rx1_pin_sel];
    st_nxt.per.pwm_ctrl_in_16 = st_r.sync2[pwm_ctrl_in_16_pin_sel];
    st_nxt.per.pwm_ctrl_in_18 = st_r.sync2[pwm_ctrl_in_18_pin_sel];
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Everything clears to zero at reset, which selects pin code 0 everywhere.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The slave never stalls and never errors.
  assign hreadyout = 1'b1;
  assign hresp = RIPS_HRESP_OKAY;
  assign hrdata = st_r.rdata;
  assign periph_in = st_r.per;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Helper view of raw pins at the chosen codes, for the end-to-end checks.
  logic raw_dsr;
  logic raw_rx;
  logic raw_sck;
  logic raw_ss;
  logic raw_tck;
  logic raw_cap;
  logic raw_p17;
  logic raw_p13;
  logic raw_p15;
  logic raw_sent;
  logic raw_p18;
  logic raw_sdat;
  logic raw_flt;
  logic raw_p12;
  logic raw_p14;
  logic raw_p16;
  logic [15:0] wr_val;
  assign raw_dsr = remappable_pin[uart3_dsr_pin_sel];
  assign raw_rx = remappable_pin[uart3_rx_pin_sel];
  assign raw_sck = remappable_pin[spi3_clock_pin_sel];
  assign raw_ss = remappable_pin[spi3_slave_sel_pin_sel];
  assign raw_tck = remappable_pin[timer9_clock_pin_sel];
  assign raw_cap = remappable_pin[capture9_pin_sel];
  assign raw_p17 = remappable_pin[pwm_ctrl_in_17_pin_sel];
  assign raw_p13 = remappable_pin[pwm_ctrl_in_13_pin_sel];
  assign raw_p15 = remappable_pin[pwm_ctrl_in_15_pin_sel];
  assign raw_sent = remappable_pin[sent_rx1_pin_sel];
  assign raw_p18 = remappable_pin[pwm_ctrl_in_18_pin_sel];
  assign raw_sdat = remappable_pin[spi3_data_pin_sel];
  assign raw_flt = remappable_pin[compare_fault_c_pin_sel];
  assign raw_p12 = remappable_pin[pwm_ctrl_in_12_pin_sel];
  assign raw_p14 = remappable_pin[pwm_ctrl_in_14_pin_sel];
  assign raw_p16 = remappable_pin[pwm_ctrl_in_16_pin_sel];
  assign wr_val = hwdata[15:0] & rips_wmask(st_r.dph_idx);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Selects unchanged over the last three cycles, and the first synchroniser
  // stage already out of reset at the edge where the pin sample was taken.
  sequence s_quiet;
    $stable(st_r.regs)[*3] ##0 $past(rstn, 3);
  endsequence

  // Write data phase in progress.
  sequence s_wr_data;
    st_r.dph_wr;
  endsequence

  // Read address phase taken on a mapped register.
  sequence s_rd_addr;
    acc && !hwrite && hit;
  endsequence

  // A pin level reaches its peripheral input exactly three edges later.
  property p_dsr;
    s_quiet |-> periph_in.uart3_data_set_ready_in == $past(raw_dsr, 3);
  endproperty
  a_dsr: assert property (p_dsr) else $error("uart3 dsr routing wrong");

  property p_rx;
    s_quiet |-> periph_in.uart3_receive_in == $past(raw_rx, 3);
  endproperty
  a_rx: assert property (p_rx) else $error("uart3 rx routing wrong");

  property p_sck;
    s_quiet |-> periph_in.spi3_clock_in == $past(raw_sck, 3);
  endproperty
  a_sck: assert property (p_sck) else $error("spi3 clock routing wrong");

  property p_ss;
    s_quiet |-> periph_in.spi3_slave_sel_in == $past(raw_ss, 3);
  endproperty
  a_ss: assert property (p_ss) else $error("spi3 slave select routing wrong");

  property p_tck;
    s_quiet |-> periph_in.timer9_ext_clock_in == $past(raw_tck, 3);
  endproperty
  a_tck: assert property (p_tck) else $error("timer9 clock routing wrong");

  property p_cap;
    s_quiet |-> periph_in.capture9_in == $past(raw_cap, 3);
  endproperty
  a_cap: assert property (p_cap) else $error("capture9 routing wrong");

  property p_p17;
    s_quiet |-> periph_in.pwm_ctrl_in_17 == $past(raw_p17, 3);
  endproperty
  a_p17: assert property (p_p17) else $error("pwm input 17 routing wrong");

  property p_p13;
    s_quiet |-> periph_in.pwm_ctrl_in_13 == $past(raw_p13, 3);
  endproperty
  a_p13: assert property (p_p13) else $error("pwm input 13 routing wrong");

  property p_p15;
    s_quiet |-> periph_in.pwm_ctrl_in_15 == $past(raw_p15, 3);
  endproperty
  a_p15: assert property (p_p15) else $error("pwm input 15 routing wrong");

  property p_sent;
    s_quiet |-> periph_in.sent_rx1_in == $past(raw_sent, 3);
  endproperty
  a_sent: assert property (p_sent) else $error("sent1 routing wrong");

  property p_p18;
    s_quiet |-> periph_in.pwm_ctrl_in_18 == $past(raw_p18, 3);
  endproperty
  a_p18: assert property (p_p18) else $error("pwm input 18 routing wrong");

  // The remaining lower-byte fields follow the same three-edge path.
  property p_sdat;
    s_quiet |-> periph_in.spi3_data_in == $past(raw_sdat, 3);
  endproperty
  a_sdat: assert property (p_sdat) else $error("spi3 data routing wrong");

  property p_flt;
    s_quiet |-> periph_in.compare_fault_c_in == $past(raw_flt, 3);
  endproperty
  a_flt: assert property (p_flt) else $error("fault C routing wrong");

  property p_p12;
    s_quiet |-> periph_in.pwm_ctrl_in_12 == $past(raw_p12, 3);
  endproperty
  a_p12: assert property (p_p12) else $error("pwm input 12 routing wrong");

  property p_p14;
    s_quiet |-> periph_in.pwm_ctrl_in_14 == $past(raw_p14, 3);
  endproperty
  a_p14: assert property (p_p14) else $error("pwm input 14 routing wrong");

  property p_p16;
    s_quiet |-> periph_in.pwm_ctrl_in_16 == $past(raw_p16, 3);
  endproperty
  a_p16: assert property (p_p16) else $error("pwm input 16 routing wrong");

  // Unused bytes stay zero whatever is written.
  property p_unused;
    s_wr_data |=> (st_r.regs[RIPS_IDX_TMR9][7:0] == 8'h00)
                  && (st_r.regs[RIPS_IDX_SS3][15:8] == 8'h00)
                  && (st_r.regs[RIPS_IDX_CAP9][15:8] == 8'h00)
                  && (st_r.regs[RIPS_IDX_PWM18][15:8] == 8'h00);
  endproperty
  a_unused: assert property (p_unused) else $error("unused byte took a write");

  // A write lands as the masked data word at the end of its data phase.
  property p_wr;
    s_wr_data |=> st_r.regs[$past(st_r.dph_idx)] == $past(wr_val);
  endproperty
  a_wr: assert property (p_wr) else $error("register write lost");

  // A read returns the register one cycle after its address phase.
  property p_rd;
    s_rd_addr |=> hrdata == {RIPS_RD_PAD, st_r.regs[$past(ap_idx)]};
  endproperty
  a_rd: assert property (p_rd) else $error("register read wrong");

  // ****************************************************************
  // Bus and synchroniser checks
  // ****************************************************************
  // Outside a read data phase the read bus rests at zero.
  property p_rd_idle;
    !(acc && !hwrite && hit) |=> hrdata == 32'h00000000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data left standing");

  // A write that misses the register window never opens a data phase.
  property p_wr_miss;
    acc && hwrite && !hit |=> !st_r.dph_wr;
  endproperty
  a_wr_miss: assert property (p_wr_miss) else $error("unmapped write accepted");

  // A mapped write address phase opens a data phase for that word.
  property p_wr_open;
    acc && hwrite && hit |=> st_r.dph_wr && (st_r.dph_idx == $past(ap_idx));
  endproperty
  a_wr_open: assert property (p_wr_open) else $error("write phase not opened");

  // Only a write data phase may change the select registers.
  property p_hold;
    !st_r.dph_wr |=> $stable(st_r.regs);
  endproperty
  a_hold: assert property (p_hold) else $error("select changed without a write");

  // The second synchroniser stage copies the first one edge later.
  property p_sync;
    st_r.sync2 == $past(st_r.sync1);
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser stage skipped");

endmodule

`default_nettype wire

/* File: tb/rips_pin_model.sv */
// Partner model: the device pins that feed the remappable input selector.
// Assumes the bench sets a probe pin and a level just after a clk_sys edge.
`timescale 1ns/1ps
`default_nettype none

module rips_pin_model (
  // Clock.
  input wire logic clk_sys,
  // Probe command from the bench.
  input wire logic [7:0] probe_code,
  input wire logic probe_lvl,
  // Pin levels seen by the selector.
  output logic [255:0] remappable_pin
);
  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // The probe pin takes the probe level and every other pin the inverse.
  // A wrong selection then reads the opposite level, never a lucky match.
  always @(posedge clk_sys) begin
    remappable_pin <= probe_lvl ? (256'h1 << probe_code) : ~(256'h1 << probe_code);
  end
endmodule

`default_nettype wire

/* File: tb/rips_top_tb.sv */
// Self-checking testbench for the remappable input selector part.
// Assumes rips_pkg, rips_top and rips_pin_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module rips_top_tb;
  import rips_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk_sys;
  logic rstn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic [RIPS_NPIN-1:0] remappable_pin;
  rips_periph_t periph_in;
  logic [7:0] probe_code;
  logic probe_lvl;
  int failures;
  int cmp_count;
  int cycles = 0;
  // Select values written for the routing test, one per register.
  logic [15:0] regv [10];
  // Implemented bits of each register, by word index.
  logic [15:0] exp_mask [10] = '{16'hFFFF, 16'hFFFF, 16'h00FF, 16'hFF00, 16'h00FF,
                                 16'hFFFF, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  // For periph_in bit k: the register index and field position that steer it.
  int fidx [16] = '{9, 6, 5, 9, 8, 8, 7, 7, 5, 4, 3, 2, 1, 1, 0, 0};
  int flsb [16] = '{8, 0, 8, 0, 8, 0, 8, 0, 0, 0, 8, 0, 0, 8, 0, 8};

  // ****************************************************************
  // Design and partner
  // ****************************************************************
  // The one slave's hreadyout is the bus's hready.
  rips_top uut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hready),
    .hresp(hresp),
    .hrdata(hrdata),
    .remappable_pin(remappable_pin),
    .periph_in(periph_in)
  );

  rips_pin_model pins (
    .clk_sys(clk_sys),
    .probe_code(probe_code),
    .probe_lvl(probe_lvl),
    .remappable_pin(remappable_pin)
  );

  // ****************************************************************
  // Clock, timeout and verdict
  // ****************************************************************
  // A 100 ns period gives the 10 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // The tests take under 1000 cycles; a hang is cut off well beyond that.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************************************
  // Compare tasks
  // ****************************************************************
  // Bus results, compared with case equality so an unknown never matches.
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Peripheral input levels.
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // ****************************************************************
  // AHB-Lite master tasks
  // ****************************************************************
  // Returns just after the first rising edge at which hready is high.
  task automatic wait_ready();
    do @(posedge clk_sys); while (hready !== 1'b1);
  endtask

  // Entered just after an edge; address phase, then data phase.
  task automatic ahb_wr(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr <= a;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask

  // Read data and response are taken at the edge that ends the data phase.
  task automatic ahb_rd_chk(input logic [31:0] a, input logic [31:0] e);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b0;
    haddr <= a;
    wait_ready();
    htrans <= 2'h0;
    wait_ready();
    chk32($sformatf("read 0x%h", a), e, hrdata);
    chk32("hresp", 32'h0, {31'h0, hresp});
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [15:0] exp;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    probe_code = 8'h0;
    probe_lvl = 1'b0;
    failures = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk_sys);
    chk16("periph_in in reset", 16'h0, periph_in);
    rstn <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 10; i++) ahb_rd_chk(32'(4 * i), 32'h0);
    // All ones land only in implemented bytes; upper half-word reads zero.
    for (int i = 0; i < 10; i++) begin
      ahb_wr(32'(4 * i), 32'hFFFFFFFF);
      ahb_rd_chk(32'(4 * i), {16'h0, exp_mask[i]});
    end
    // Unmapped index changes nothing and reads zero; a misaligned write leaves word 0 unchanged.
    ahb_wr(32'h28, 32'hFFFFFFFF);
    ahb_rd_chk(32'h28, 32'h0);
    ahb_wr(32'h1, 32'h0);
    ahb_rd_chk(32'h0, 32'h0000FFFF);
    // Distinct codes per field, spanning 0x00 to 0xFF.
    for (int i = 0; i < 10; i++) regv[i] = 16'h0;
    for (int k = 0; k < 16; k++) regv[fidx[k]] = regv[fidx[k]] | (16'(k * 17) << flsb[k]);
    for (int i = 0; i < 10; i++) ahb_wr(32'(4 * i), {16'hA5A5, regv[i]});
    for (int i = 0; i < 10; i++) ahb_rd_chk(32'(4 * i), {16'h0, regv[i]});
    // Raise and lower each selected pin alone; every other input must differ.
    for (int k = 0; k < 16; k++) begin
      for (int l = 0; l < 2; l++) begin
        probe_code <= 8'(k * 17);
        probe_lvl <= l[0];
        exp = (l == 1) ? (16'h1 << k) : ~(16'h1 << k);
        // One edge in the model, two in the synchroniser, one at the output.
        repeat (5) @(posedge clk_sys);
        chk16($sformatf("periph_in bit %0d", k), exp, periph_in);
      end
    end
    // A second reset in mid-run clears every field again.
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk16("periph_in in reset", 16'h0, periph_in);
    rstn <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 10; i++) ahb_rd_chk(32'(4 * i), 32'h0);
    close_out();
  end
endmodule

`default_nettype wire
